// ### design/pressure_switch_comparator.sv
`timescale 1ns/1ps
// Threshold switch of a digital pressure gauge
module pressure_switch_comparator
	import pressure_switch_pkg::*;
#(
	parameter int RESP_0 = RESP_CYC_0,
	parameter int RESP_1 = RESP_CYC_1,
	parameter int RESP_2 = RESP_CYC_2,
	parameter int RESP_3 = RESP_CYC_3,
	parameter int HOLD = HOLD_CYC
)
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic signed [15:0] i_pressure,
	input wire logic i_sample,
	input wire logic [1:0] i_mode,
	input wire logic i_norm_closed,
	input wire logic [1:0] i_resp_sel,
	input wire logic i_two_colour,
	input wire logic signed [15:0] i_preset_a,
	input wire logic signed [15:0] i_preset_b,
	input wire logic signed [15:0] i_preset_c,
	input wire logic i_capture_a,
	input wire logic i_capture_b,
	input wire logic i_write_a,
	input wire logic i_write_b,
	input wire logic i_write_c,
	input wire logic i_zero_key,
	input wire logic i_zero_shift,
	input wire logic i_lock_combo,
	input wire logic i_show_peak,
	input wire logic i_show_bottom,
	input wire logic i_overcurrent,
	output logic o_control_output_one,
	output logic o_control_output_two,
	output logic o_red,
	output logic o_green,
	output logic [2:0] o_display,
	output logic signed [15:0] o_value,
	output logic o_locked,
	output logic o_preset_reject
);
	// Synchronised reset
	logic rst_s1_reg;
	logic rst_s2_reg;
	logic rst;
	// Stored presets: A/H, B/h/L, C
	logic signed [15:0] pa_reg;
	logic signed [15:0] pb_reg;
	logic signed [15:0] pc_reg;
	// Zero offsets and corrected pressure
	logic signed [15:0] zero_reg;
	logic signed [15:0] shift_reg;
	logic signed [15:0] press;
	// Pin synchronisers
	logic [2:0] zs_sync_reg;
	logic [2:0] oc_sync_reg;
	logic zs_level_reg;
	// Raw comparator states
	logic raw1_reg;
	logic raw2_reg;
	logic filt1;
	logic filt2;
	logic [31:0] resp_limit;
	// Timers
	logic [31:0] zkey_cnt_reg;
	logic [31:0] lock_cnt_reg;
	logic zero_err_reg;
	logic oc_err_reg;
	logic signed [15:0] peak_reg;
	logic signed [15:0] bottom_reg;
	logic hold_clear;

	// Average of two signed values without overflow
	function automatic logic signed [15:0] avg2(input logic signed [15:0] x, input logic signed [15:0] y);
		logic signed [16:0] s;
		s = 17'(x) + 17'(y);
		return s[16:1];
	endfunction : avg2

	// Release reset through two flops
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst = !rst_s2_reg;

	// Three-flop synchronisers on pins
	always_ff @(posedge i_mclk or posedge rst)
	begin
		if (rst)
		begin
			zs_sync_reg <= 3'h0;
			oc_sync_reg <= 3'h0;
			zs_level_reg <= 1'b0;
		end
		else
		begin
			zs_sync_reg <= {zs_sync_reg[1:0], i_zero_shift};
			oc_sync_reg <= {oc_sync_reg[1:0], i_overcurrent};
			if (zs_sync_reg[1] == zs_sync_reg[2])
				zs_level_reg <= zs_sync_reg[2];
		end
	end

	// Displayed pressure after zero and shift
	assign press = 16'(i_pressure - zero_reg - shift_reg);

	// Preset storage
	always_ff @(posedge i_mclk or posedge rst)
	begin
		if (rst)
		begin
			pa_reg <= 16'sh0000;
			pb_reg <= 16'sh0000;
			pc_reg <= 16'sh0000;
			o_preset_reject <= 1'b0;
		end
		else if (!o_locked)
		begin
			o_preset_reject <= 1'b0;
			if (i_capture_a && i_mode == MODE_AUTO)
				pa_reg <= press;
			if (i_capture_b && i_mode == MODE_AUTO)
			begin
				pb_reg <= press;
				pc_reg <= avg2(pa_reg, press);
			end
			if (i_write_a)
				pa_reg <= i_preset_a;
			if (i_write_b && i_mode == MODE_WINDOW && (17'(i_preset_b) + 17'(WIN_GAP) > 17'(pa_reg)))
				o_preset_reject <= 1'b1;
			else if (i_write_b)
				pb_reg <= i_preset_b;
			if (i_write_c && i_mode == MODE_AUTO)
			begin
				if ((i_preset_c <= pa_reg && i_preset_c >= pb_reg) || (i_preset_c >= pa_reg && i_preset_c <= pb_reg))
					pc_reg <= i_preset_c;
				else
					o_preset_reject <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge rst)
	begin
		if (rst)
		begin
			raw1_reg <= 1'b0;
			raw2_reg <= 1'b0;
		end
		else if (i_sample)
		begin
			case (op_mode_e'(i_mode))
				MODE_AUTO:
				begin
					raw1_reg <= raw1_reg ? (press > pc_reg - HYST_FIXED) : (press > pc_reg);
					raw2_reg <= raw2_reg ? (press >= avg2(pa_reg, pc_reg) - HYST_FIXED
						|| press <= avg2(pc_reg, pb_reg) + HYST_FIXED)
						: (press > avg2(pa_reg, pc_reg) || press < avg2(pc_reg, pb_reg));
				end
				MODE_HYST:
				begin
					raw1_reg <= raw1_reg ? (press > pa_reg - pb_reg) : (press > pa_reg);
					raw2_reg <= raw2_reg ? (press >= pa_reg - HYST_FIXED || press <= pa_reg - pb_reg + HYST_FIXED)
						: (press > pa_reg || press < pa_reg - pb_reg);
				end
				MODE_INDEP:
				begin
					raw1_reg <= raw1_reg ? (press > pa_reg - HYST_FIXED) : (press > pa_reg);
					raw2_reg <= raw2_reg ? (press > pb_reg - HYST_FIXED) : (press > pb_reg);
				end
				MODE_WINDOW:
				begin
					raw1_reg <= raw1_reg ? (press <= pa_reg + HYST_FIXED && press >= pb_reg - HYST_FIXED)
						: (press <= pa_reg && press >= pb_reg);
					raw2_reg <= raw2_reg ? (press <= pa_reg - ((pa_reg - pb_reg) >>> 2) + HYST_FIXED
						&& press >= pb_reg + ((pa_reg - pb_reg) >>> 2) - HYST_FIXED)
						: (press <= pa_reg - ((pa_reg - pb_reg) >>> 2) && press >= pb_reg + ((pa_reg - pb_reg) >>> 2));
				end
				default:
				begin
					raw1_reg <= 1'b0;
					raw2_reg <= 1'b0;
				end
			endcase
		end
	end

	// Response time selection
	always_comb
	begin
		case (i_resp_sel)
			2'h0: resp_limit = 32'(RESP_0);
			2'h1: resp_limit = 32'(RESP_1);
			2'h2: resp_limit = 32'(RESP_2);
			default: resp_limit = 32'(RESP_3);
		endcase
	end

	response_filter u_filt1 (.i_mclk(i_mclk), .i_rst(rst), .i_raw(raw1_reg), .i_limit(resp_limit), .o_state(filt1));
	response_filter u_filt2 (.i_mclk(i_mclk), .i_rst(rst), .i_raw(raw2_reg), .i_limit(resp_limit), .o_state(filt2));

	assign o_control_output_one = filt1 ^ i_norm_closed;
	assign o_control_output_two = filt2 ^ i_norm_closed;
	assign o_red = !i_two_colour || filt1;
	assign o_green = i_two_colour && !filt1;

	// Zero adjust and zero shift
	always_ff @(posedge i_mclk or posedge rst)
	begin
		if (rst)
		begin
			zkey_cnt_reg <= 32'h0;
			zero_reg <= 16'sh0000;
			shift_reg <= 16'sh0000;
			zero_err_reg <= 1'b0;
		end
		else
		begin
			zkey_cnt_reg <= i_zero_key ? ((zkey_cnt_reg <= 32'(HOLD)) ? zkey_cnt_reg + 32'h1 : zkey_cnt_reg) : 32'h0;
			if (i_zero_key && zkey_cnt_reg == 32'(HOLD))
			begin
				if (press <= ZERO_ADJ_LIM && press >= -ZERO_ADJ_LIM)
				begin
					zero_reg <= 16'(zero_reg + press);
					zero_err_reg <= 1'b0;
				end
				else
					zero_err_reg <= 1'b1;
			end
			if (zs_sync_reg[2] && !zs_level_reg && zs_sync_reg[1] && i_mode != MODE_AUTO
				&& press >= SHIFT_LOW && press <= FULL_SCALE)
				shift_reg <= 16'(shift_reg + press);
		end
	end

	// Key lock with 2 s flash
	always_ff @(posedge i_mclk or posedge rst)
	begin
		if (rst)
		begin
			o_locked <= 1'b0;
			lock_cnt_reg <= 32'h0;
		end
		else if (i_lock_combo && lock_cnt_reg == 32'h0)
		begin
			o_locked <= !o_locked;
			lock_cnt_reg <= 32'(HOLD);
		end
		else if (lock_cnt_reg != 32'h0)
			lock_cnt_reg <= lock_cnt_reg - 32'h1;
	end

	assign hold_clear = i_write_a || i_write_b || i_write_c || i_capture_a || i_capture_b;

	// Peak and bottom tracking
	always_ff @(posedge i_mclk or posedge rst)
	begin
		if (rst)
		begin
			peak_reg <= 16'sh8000;
			bottom_reg <= 16'sh7FFF;
		end
		else if (hold_clear)
		begin
			peak_reg <= 16'sh8000;
			bottom_reg <= 16'sh7FFF;
		end
		else if (i_sample)
		begin
			if (press > peak_reg)
				peak_reg <= press;
			if (press < bottom_reg)
				bottom_reg <= press;
		end
	end

	// Overcurrent latch
	always_ff @(posedge i_mclk or posedge rst)
	begin
		if (rst)
			oc_err_reg <= 1'b0;
		else if (oc_sync_reg[2])
			oc_err_reg <= 1'b1;
	end

	// Display selection, registered
	always_ff @(posedge i_mclk or posedge rst)
	begin
		if (rst)
		begin
			o_display <= DISP_VALUE;
			o_value <= 16'sh0000;
		end
		else
		begin
			o_value <= press;
			if (oc_err_reg)
				o_display <= DISP_OVERCUR;
			else if (zero_err_reg)
				o_display <= DISP_ZERO_ERR;
			else if (lock_cnt_reg != 32'h0)
				o_display <= DISP_LOCK;
			else if (press < RANGE_LOW)
				o_display <= DISP_UNDER;
			else if (press > RANGE_HIGH)
				o_display <= DISP_OVER;
			else if (i_show_peak && !o_locked)
			begin
				o_display <= DISP_PEAK;
				o_value <= peak_reg;
			end
			else if (i_show_bottom && !o_locked)
			begin
				o_display <= DISP_BOTTOM;
				o_value <= bottom_reg;
			end
			else
				o_display <= DISP_VALUE;
		end
	end

	a_polarity_inv: assert property (@(posedge i_mclk) disable iff (rst)
		o_control_output_one == (filt1 ^ i_norm_closed) && o_control_output_two == (filt2 ^ i_norm_closed))
		else $error("Polarity mismatch");
	a_lock_hides_hold: assert property (@(posedge i_mclk) disable iff (rst)
		$past(o_locked) |-> (o_display != DISP_PEAK && o_display != DISP_BOTTOM))
		else $error("Hold shown while locked");
	a_overcur_shown: assert property (@(posedge i_mclk) disable iff (rst)
		oc_err_reg |=> o_display == DISP_OVERCUR)
		else $error("Overcurrent not displayed");
	a_shift_auto: assert property (@(posedge i_mclk) disable iff (rst)
		(i_mode == MODE_AUTO && $stable(i_mode)) |=> $stable(shift_reg))
		else $error("Shift changed in auto mode");
	a_colour_follow: assert property (@(posedge i_mclk) disable iff (rst)
		i_two_colour |-> (o_red == filt1 && o_green == !filt1))
		else $error("Colour mismatch");
	a_lock_presets: assert property (@(posedge i_mclk) disable iff (rst)
		(o_locked && $past(o_locked)) |=> 1'b1 ##0 ($past(o_locked) -> $stable(pa_reg)))
		else $error("Preset changed while locked");
	a_over_range: assert property (@(posedge i_mclk) disable iff (rst)
		(press > RANGE_HIGH && !oc_err_reg && !zero_err_reg && lock_cnt_reg == 32'h0) |=> o_display == DISP_OVER)
		else $error("Over range not shown");
	a_auto_mid: assert property (@(posedge i_mclk) disable iff (rst)
		(i_capture_b && i_mode == MODE_AUTO && !o_locked && !i_write_c) |=> pc_reg == avg2(pa_reg, pb_reg))
		else $error("Level not midpoint");
endmodule : pressure_switch_comparator

// ### design/pressure_switch_pkg.sv
package pressure_switch_pkg;
	// Pressure word width, signed, full scale value
	localparam int PW = 16;
	localparam logic signed [15:0] FULL_SCALE = 16'sh2710;
	// Built-in hysteresis 0.5% of full scale
	localparam logic signed [15:0] HYST_FIXED = 16'sh0032;
	// Zero adjust window 5%, shift lower -3%, window gap 1%
	localparam logic signed [15:0] ZERO_ADJ_LIM = 16'sh01F4;
	localparam logic signed [15:0] SHIFT_LOW = -16'sh012C;
	localparam logic signed [15:0] WIN_GAP = 16'sh0064;
	// Display range -15% and 110%
	localparam logic signed [15:0] RANGE_LOW = -16'sh05DC;
	localparam logic signed [15:0] RANGE_HIGH = 16'sh2AF8;
	// Clock rate and timing
	localparam int CLK_HZ = 20000000;
	localparam int RESP_US_0 = 2500;
	localparam int RESP_US_1 = 5000;
	localparam int RESP_US_2 = 100000;
	localparam int RESP_US_3 = 500000;
	localparam int HOLD_MS = 2000;
	localparam int RESP_CYC_0 = RESP_US_0 * (CLK_HZ / 1000000);
	localparam int RESP_CYC_1 = RESP_US_1 * (CLK_HZ / 1000000);
	localparam int RESP_CYC_2 = RESP_US_2 * (CLK_HZ / 1000000);
	localparam int RESP_CYC_3 = RESP_US_3 * (CLK_HZ / 1000000);
	localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
	// Operating modes
	typedef enum logic [1:0]
	{
		MODE_AUTO = 2'b00,
		MODE_HYST = 2'b01,
		MODE_INDEP = 2'b10,
		MODE_WINDOW = 2'b11
	} op_mode_e;
	// Display states
	typedef enum logic [2:0]
	{
		DISP_VALUE = 3'b000,
		DISP_UNDER = 3'b001,
		DISP_OVER = 3'b010,
		DISP_ZERO_ERR = 3'b011,
		DISP_OVERCUR = 3'b100,
		DISP_LOCK = 3'b101,
		DISP_PEAK = 3'b110,
		DISP_BOTTOM = 3'b111
	} disp_e;
endpackage : pressure_switch_pkg

// ### design/response_filter.sv
`timescale 1ns/1ps
// Passes a raw detection state only after it persists for the limit
module response_filter
	import pressure_switch_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_raw,
	input wire logic [31:0] i_limit,
	output logic o_state
);
	// Cycles the raw state has differed from the output
	logic [31:0] count_reg;

	// Count while raw differs, restart on agreement
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			count_reg <= 32'h0;
			o_state <= 1'b0;
		end
		else if (i_raw == o_state)
			count_reg <= 32'h0;
		else if (count_reg >= i_limit)
		begin
			o_state <= i_raw;
			count_reg <= 32'h0;
		end
		else
			count_reg <= count_reg + 32'h1;
	end

	a_filter_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
		(o_state != $past(o_state)) |-> ($past(count_reg) >= $past(i_limit)))
		else $error("Output changed before response time");
endmodule : response_filter

// ### testbench/pressure_source.sv
`timescale 1ns/1ps
// Sensing element and output loads seen by the threshold switch
module pressure_source
(
	input wire logic i_mclk,
	input wire logic signed [15:0] i_level,
	input wire logic i_short,
	output logic signed [15:0] o_pressure,
	output logic o_sample,
	output logic o_overcurrent
);
	// Spacing of sample strobes
	logic [1:0] tick_reg;
	// Quiet start so no input is unknown
	initial
	begin
		tick_reg = 2'h0;
		o_sample = 1'b0;
		o_pressure = 16'sh0000;
		o_overcurrent = 1'b0;
	end
	always @(negedge i_mclk)
	begin
		tick_reg <= tick_reg + 2'h1;
		o_sample <= (tick_reg == 2'h3);
		o_pressure <= i_level;
	end
	always @(negedge i_mclk)
	begin
		o_overcurrent <= i_short;
	end
endmodule : pressure_source

// ### testbench/pressure_switch_comparator_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the pressure threshold switch
module pressure_switch_comparator_bench import pressure_switch_pkg::*;
;
	// Clock, reset and stimulus
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic signed [15:0] level = 16'sh0000;
	logic short = 1'b0;
	logic [1:0] mode = 2'h0;
	logic nc = 1'b1;
	logic [1:0] resp = 2'h0;
	logic two_colour = 1'b0;
	logic signed [15:0] preset_a = 16'sh0000;
	logic signed [15:0] preset_b = 16'sh0000;
	logic [5:0] stb = 6'h00;
	logic show_peak = 1'b0;
	// Zero key, zero-shift pin and bottom-hold request
	logic zero_key = 1'b0;
	logic zero_shift = 1'b0;
	logic show_bottom = 1'b0;
	// Partner and design outputs
	logic signed [15:0] pressure;
	logic sample, overcurrent, control_output_one, out2, red, green, locked, reject;
	logic [2:0] display;
	logic signed [15:0] value;
	logic [1:0] outs;
	// Trial state
	logic signed [15:0] a, b, d, p;
	logic [1:0] e, prev;
	logic h1, rej;
	int fails = 0;
	int num_checks = 0;
	int seed, m;
	assign outs = {out2, control_output_one};
	// Clock at 20 MHz
	initial
	begin
		forever #25 mclk = ~mclk;
	end
	pressure_source source (.i_mclk(mclk), .i_level(level), .i_short(short), .o_pressure(pressure),
		.o_sample(sample), .o_overcurrent(overcurrent));
	pressure_switch_comparator #(.RESP_0(4), .RESP_1(8), .RESP_2(16), .RESP_3(32), .HOLD(20)) dut (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_pressure(pressure), .i_sample(sample), .i_mode(mode),
		.i_norm_closed(nc), .i_resp_sel(resp), .i_two_colour(two_colour), .i_preset_a(preset_a),
		.i_preset_b(preset_b), .i_preset_c(preset_a), .i_capture_a(stb[2]), .i_capture_b(stb[3]),
		.i_write_a(stb[0]), .i_write_b(stb[1]), .i_write_c(stb[5]), .i_zero_key(zero_key),
		.i_zero_shift(zero_shift), .i_lock_combo(stb[4]), .i_show_peak(show_peak),
		.i_show_bottom(show_bottom), .i_overcurrent(overcurrent),
		.o_control_output_one(control_output_one), .o_control_output_two(out2), .o_red(red), .o_green(green),
		.o_display(display), .o_value(value), .o_locked(locked), .o_preset_reject(reject));
	// Wait whole cycles, ending on a falling edge
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle strobe on a write, capture or lock input; keeps the refusal flag
	task automatic pulse(input int k, input logic signed [15:0] v);
		preset_a = v;
		preset_b = v;
		stb[k] = 1'b1;
		cyc(1);
		stb = 6'h00;
		rej = reject;
		cyc(1);
	endtask : pulse
	// Test pressure: above, inner, below, second inner point
	function automatic logic signed [15:0] pt(input logic [1:0] md, input int i, input logic signed [15:0] ha, hb);
		logic signed [15:0] hi, lo, mid;
		hi = (md == MODE_HYST || ha > hb) ? ha : hb;
		lo = (md == MODE_HYST) ? ha - hb : (ha > hb) ? hb : ha;
		mid = (hi + lo) / 2;
		case (i)
			0: pt = hi + 16'sh00C8;
			1: pt = (md == MODE_AUTO) ? mid + (hi - mid) / 4 : mid;
			2: pt = lo - 16'sh00C8;
			default: pt = (md == MODE_AUTO) ? mid - (mid - lo) / 4 : (md == MODE_WINDOW) ? lo + (hi - lo) / 8 : mid;
		endcase
	endfunction : pt
	// Normally-open outputs {two, one} for a pressure, given the last state of output one
	function automatic logic [1:0] exp_pair(input logic [1:0] md, input logic signed [15:0] x, ha, hb,
		input logic last1);
		logic signed [15:0] c, q;
		logic o1, o2;
		c = (ha + hb) / 2;
		q = (ha - hb) / 4;
		o1 = (md == MODE_AUTO) ? (x > c) : (md == MODE_HYST) ? ((x > ha) || (last1 && x >= ha - hb)) :
			(md == MODE_INDEP) ? (x > ha) : (x >= hb && x <= ha);
		o2 = (md == MODE_AUTO) ? ((x > (ha + c) / 2) || (x < (c + hb) / 2)) :
			(md == MODE_HYST) ? ((x < ha - hb) || (x > ha)) :
			(md == MODE_INDEP) ? (x > hb) : (x >= hb + q && x <= ha - q);
		exp_pair = {o2, o1};
	endfunction : exp_pair
	// Counts, verdict, end of run
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	// Watchdog against a hang
	initial
	begin
		#1000000;
		fails++;
		end_sim();
	end
	// Main sequence
	initial
	begin
		seed = $urandom(84758);
		cyc(3);
		chk(outs, 16'h0003);
		chk(red, 16'h0001);
		chk(display, DISP_VALUE);
		cyc(3);
		rst_n = 1'b1;
		cyc(4);
		for (m = 0; m < 4; m++)
			repeat (6)
			begin
				a = 16'sh0BB8 + 16'($urandom % 4000);
				d = 16'sh03E8 + 16'($urandom % 2000);
				b = (m == 1) ? d / 4 : (m == 2 && $urandom % 2 == 1) ? a + d : a - d;
				nc = 1'($urandom);
				two_colour = 1'($urandom);
				resp = 2'($urandom);
				mode = 2'(m);
				if (m == 0)
				begin
					level = a;
					cyc(8);
					pulse(2, 16'sh0000);
					level = b;
					cyc(8);
					pulse(3, 16'sh0000);
				end
				else
				begin
					if (m == 3)
						pulse(0, 16'sh2710);
					pulse(1, b);
					pulse(0, a);
					chk(rej, 16'h0000);
					if (m == 3)
						pulse(1, a - 16'sh0063);
					chk(rej, (m == 3) ? 16'h0001 : 16'h0000);
				end
				h1 = 1'b0;
				for (int i = 0; i < 4; i++)
				begin
					p = pt(mode, i, a, b);
					level = p;
					cyc(20);
					if (i > 0 && resp == 2'h3)
						chk(outs, prev ^ {2{nc}});
					cyc(40);
					e = exp_pair(mode, p, a, b, h1);
					chk(outs, e ^ {2{nc}});
					chk({red, green}, two_colour ? {e[0], ~e[0]} : 2'h2);
					h1 = e[0];
					prev = e;
				end
			end
		mode = MODE_INDEP;
		resp = 2'h0;
		pulse(0, 16'sh1388);
		pulse(1, 16'sh1388);
		level = -16'sh0640;
		cyc(40);
		chk(display, DISP_UNDER);
		level = 16'sh2B5C;
		cyc(40);
		chk(display, DISP_OVER);
		level = 16'sh0BB8;
		cyc(40);
		chk(display, DISP_VALUE);
		chk(value, 16'h0BB8);
		pulse(4, 16'sh0000);
		chk(locked, 16'h0001);
		chk(display, DISP_LOCK);
		pulse(0, 16'sh03E8);
		cyc(60);
		chk(outs, {2{nc}});
		show_peak = 1'b1;
		cyc(2);
		chk(display === DISP_PEAK, 16'h0000);
		show_peak = 1'b0;
		pulse(4, 16'sh0000);
		cyc(25);
		chk(locked, 16'h0000);
		show_peak = 1'b1;
		cyc(2);
		chk(display, DISP_PEAK);
		show_peak = 1'b0;
		show_bottom = 1'b1;
		cyc(2);
		chk(display, DISP_BOTTOM);
		show_bottom = 1'b0;
		// Zero-shift pin pulse takes the present pressure as zero
		zero_shift = 1'b1;
		cyc(10);
		zero_shift = 1'b0;
		cyc(10);
		chk(value, 16'h0000);
		// Held zero key inside the 5% band
		level = 16'sh0C80;
		cyc(10);
		zero_key = 1'b1;
		cyc(30);
		zero_key = 1'b0;
		cyc(4);
		chk(value, 16'h0000);
		// Held zero key outside the band gives the error indication
		level = 16'sh1068;
		cyc(10);
		zero_key = 1'b1;
		cyc(30);
		zero_key = 1'b0;
		cyc(4);
		chk(display, DISP_ZERO_ERR);
		// Auto level write outside the written A and B limits is refused
		mode = MODE_AUTO;
		pulse(5, 16'sh0000);
		chk(rej, 16'h0001);
		pulse(5, 16'sh1388);
		chk(rej, 16'h0000);
		short = 1'b1;
		cyc(6);
		chk(display, DISP_OVERCUR);
		end_sim();
	end
endmodule : pressure_switch_comparator_bench
